// ### src/hgt_top.sv
// Trigger, sequencer slots and waveform time trims of the playback engine
// Notes on behaviour
// - Setting the trigger bit starts the process the mode input selects.
// - Sequencer mode: trigger plays waveform ids from the eight slots.
// - Trigger reads one while the sequence plays, cleared by hardware after.
// - Writing zero to the trigger during playback aborts the sequence.
// - Calibration and diagnostics modes: trigger launches that process; other mode codes clear it.
// - Trigger register: bit 0 read/write, resets to zero, bits 7-1 reserved.
// - Overdrive trim is eight bits, scaled by the step interval in ms.
// - Peak amplitude segment of a waveform is its overdrive portion.
// - Overdrive trim applies in open loop only, ignored in closed loop.
// - Overdrive trim is two's complement: lengthens or shortens.
// - Sustain trim: eight-bit two's complement, scaled by step interval.
// - Positive amplitudes other than overdrive take the sustain trim.
// - Sequencer advances per slot; stops at zero id or after slot eight.
// - Slot with wait flag idles ten ms times its seven-bit value.
`timescale 1ns/100ps
module hgt_top #(
    parameter int MS_CYCLES = hgt_pkg::MS_CYCLES
) (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire hgt_pkg::hgt_reg_req_s reg_req,
    output logic [7:0]                reg_rdata,
    input  wire logic [2:0]           op_mode,
    input  wire logic                 closed_loop,
    input  wire logic                 step_interval_select,
    input  wire logic                 proc_done,
    input  wire hgt_pkg::hgt_lib_rsp_s lib_rsp,
    output logic                      lib_rd,
    output logic [6:0]                lib_id,
    output logic [3:0]                lib_seg,
    output logic                      drive_en,
    output logic [7:0]                drive_amp,
    output logic                      calib_start,
    output logic                      diag_start
);
    import hgt_pkg::*;

    hgt_state_e        state_r, state_nxt;
    logic              trig_r, trig_nxt;
    logic [7:0]        odt_r, odt_nxt, spt_r, spt_nxt, rdata_r, rdata_nxt;
    logic [7:0]        slot_r [NUM_SLOTS];
    logic [7:0]        slot_nxt [NUM_SLOTS];
    logic [2:0]        idx_r, idx_nxt;
    logic [3:0]        seg_r, seg_nxt;
    logic [6:0]        id_r, id_nxt;
    logic signed [7:0] peak_r, peak_nxt, amp_r, amp_nxt;
    logic              last_r, last_nxt, en_r, en_nxt, rd_r, rd_nxt;
    logic              cal_r, cal_nxt, dia_r, dia_nxt;
    logic [16:0]       ms_r, ms_nxt;
    logic [15:0]       tick_r, tick_nxt;
    logic [7:0]        interval_ms, cur;
    logic [15:0]       base_ms;
    logic [16:0]       dur_ms;
    logic              trig_w1, trig_w0, adv, seq_busy;

    assign reg_rdata   = rdata_r;
    assign lib_rd      = rd_r;
    assign lib_id      = id_r;
    assign lib_seg     = seg_r;
    assign drive_en    = en_r;
    assign drive_amp   = amp_r;
    assign calib_start = cal_r;
    assign diag_start  = dia_r;

    // Trigger writes and the current slot
    assign trig_w1 = reg_req.wr && reg_req.addr == ADDR_TRIG
                     && reg_req.wdata[TRIG_BIT];
    assign trig_w0 = reg_req.wr && reg_req.addr == ADDR_TRIG
                     && !reg_req.wdata[TRIG_BIT];
    assign cur      = slot_r[idx_r];
    assign seq_busy = state_r inside {ST_SLOT, ST_SCAN, ST_FETCH, ST_RUN,
                                      ST_WAIT};
    assign interval_ms = step_interval_select ? INTERVAL_FAST_MS
                                              : INTERVAL_SLOW_MS;

    hgt_seg_dur u_dur (
        .amp         (lib_rsp.amp),
        .peak        (peak_r),
        .len         (lib_rsp.len),
        .interval_ms (interval_ms),
        .od_trim     (odt_r),
        .sp_trim     (spt_r),
        .closed_loop (closed_loop),
        .base_ms     (base_ms),
        .dur_ms      (dur_ms)
    );

    // Slot registers, one per sequencer entry
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SLOTS; gi++) begin : g_slot
            always_comb begin
                slot_nxt[gi] = slot_r[gi];
                if (reg_req.wr && reg_req.addr == ADDR_SLOT0 + 8'(gi)) begin
                    slot_nxt[gi] = reg_req.wdata;
                end
            end
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    slot_r[gi] <= SLOT_RST;
                end else begin
                    slot_r[gi] <= slot_nxt[gi];
                end
            end
        end
    endgenerate

    // Trim registers and read data
    always_comb begin
        odt_nxt   = odt_r;
        spt_nxt   = spt_r;
        rdata_nxt = rdata_r;
        if (reg_req.wr && reg_req.addr == ADDR_ODT) begin
            odt_nxt = reg_req.wdata;
        end
        if (reg_req.wr && reg_req.addr == ADDR_SPT) begin
            spt_nxt = reg_req.wdata;
        end
        if (reg_req.rd) begin
            if (reg_req.addr >= ADDR_SLOT0 && reg_req.addr < ADDR_TRIG) begin
                rdata_nxt = slot_r[reg_req.addr[2:0] - ADDR_SLOT0[2:0]];
            end else if (reg_req.addr == ADDR_TRIG) begin
                rdata_nxt = {7'h00, trig_r};
            end else if (reg_req.addr == ADDR_ODT) begin
                rdata_nxt = odt_r;
            end else if (reg_req.addr == ADDR_SPT) begin
                rdata_nxt = spt_r;
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            odt_r   <= TRIM_RST;
            spt_r   <= TRIM_RST;
            rdata_r <= 8'h00;
        end else begin
            odt_r   <= odt_nxt;
            spt_r   <= spt_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Playback engine next state
    always_comb begin
        state_nxt = state_r;
        trig_nxt  = trig_r;
        idx_nxt   = idx_r;
        seg_nxt   = seg_r;
        id_nxt    = id_r;
        peak_nxt  = peak_r;
        amp_nxt   = amp_r;
        last_nxt  = last_r;
        en_nxt    = en_r;
        ms_nxt    = ms_r;
        tick_nxt  = tick_r;
        rd_nxt    = 1'b0;
        cal_nxt   = 1'b0;
        dia_nxt   = 1'b0;
        adv       = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (trig_w1 || trig_r) begin
                    trig_nxt = 1'b1;
                    case (op_mode)
                        MODE_SEQ: begin
                            idx_nxt   = 3'h0;
                            state_nxt = ST_SLOT;
                        end
                        MODE_CALIB: begin
                            cal_nxt   = 1'b1;
                            state_nxt = ST_PROC;
                        end
                        MODE_DIAG: begin
                            dia_nxt   = 1'b1;
                            state_nxt = ST_PROC;
                        end
                        default: trig_nxt = 1'b0;
                    endcase
                end
            end
            ST_SLOT: begin
                if (cur[SLOT_WAIT_BIT]) begin
                    ms_nxt    = 17'(cur[6:0] * WAIT_UNIT_MS);
                    tick_nxt  = 16'h0000;
                    state_nxt = ST_WAIT;
                end else if (cur[6:0] == 7'h00) begin
                    trig_nxt  = trig_w1;
                    state_nxt = ST_IDLE;
                end else begin
                    id_nxt    = cur[6:0];
                    seg_nxt   = 4'h0;
                    peak_nxt  = 8'sh80;
                    rd_nxt    = 1'b1;
                    state_nxt = ST_SCAN;
                end
            end
            ST_SCAN: begin
                if (lib_rsp.ack) begin
                    if (lib_rsp.amp > peak_r) begin
                        peak_nxt = lib_rsp.amp;
                    end
                    seg_nxt   = lib_rsp.last ? 4'h0 : seg_r + 4'h1;
                    rd_nxt    = 1'b1;
                    state_nxt = lib_rsp.last ? ST_FETCH : ST_SCAN;
                end
            end
            ST_FETCH: begin
                if (lib_rsp.ack) begin
                    amp_nxt   = lib_rsp.amp;
                    en_nxt    = 1'b1;
                    ms_nxt    = dur_ms;
                    tick_nxt  = 16'h0000;
                    last_nxt  = lib_rsp.last;
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN, ST_WAIT: begin
                if (ms_r == 17'h00000) begin
                    if (state_r == ST_RUN && !last_r) begin
                        seg_nxt   = seg_r + 4'h1;
                        rd_nxt    = 1'b1;
                        state_nxt = ST_FETCH;
                    end else begin
                        en_nxt = 1'b0;
                        adv    = 1'b1;
                    end
                end else if (tick_r == 16'(MS_CYCLES - 1)) begin
                    tick_nxt = 16'h0000;
                    ms_nxt   = ms_r - 17'h00001;
                end else begin
                    tick_nxt = tick_r + 16'h0001;
                end
            end
            ST_PROC: begin
                if (proc_done) begin
                    trig_nxt  = trig_w1;
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        // Next slot or end of sequence
        if (adv) begin
            if (idx_r == 3'(NUM_SLOTS - 1)) begin
                trig_nxt  = trig_w1;
                state_nxt = ST_IDLE;
            end else begin
                idx_nxt   = idx_r + 3'h1;
                state_nxt = ST_SLOT;
            end
        end
        // Software clear cancels the sequence
        if (trig_w0 && seq_busy) begin
            trig_nxt  = 1'b0;
            en_nxt    = 1'b0;
            rd_nxt    = 1'b0;
            state_nxt = ST_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
            trig_r  <= TRIG_RST;
            idx_r   <= 3'h0;
            seg_r   <= 4'h0;
            id_r    <= 7'h00;
            peak_r  <= 8'sh00;
            amp_r   <= 8'sh00;
            last_r  <= 1'b0;
            en_r    <= 1'b0;
            ms_r    <= 17'h00000;
            tick_r  <= 16'h0000;
            rd_r    <= 1'b0;
            cal_r   <= 1'b0;
            dia_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            trig_r  <= trig_nxt;
            idx_r   <= idx_nxt;
            seg_r   <= seg_nxt;
            id_r    <= id_nxt;
            peak_r  <= peak_nxt;
            amp_r   <= amp_nxt;
            last_r  <= last_nxt;
            en_r    <= en_nxt;
            ms_r    <= ms_nxt;
            tick_r  <= tick_nxt;
            rd_r    <= rd_nxt;
            cal_r   <= cal_nxt;
            dia_r   <= dia_nxt;
        end
    end

    // Checks on the engine
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic seg_take;
    assign seg_take = state_r == ST_FETCH && lib_rsp.ack && !trig_w0;

    property p_seq_start;
        state_r == ST_IDLE && trig_w1 && op_mode == MODE_SEQ
        |=> state_r == ST_SLOT && trig_r && idx_r == 3'h0;
    endproperty
    a_seq_start: assert property (p_seq_start)
        else $error("sequencer not started by trigger");

    property p_proc_start;
        state_r == ST_IDLE && trig_w1 && op_mode == MODE_CALIB
        |=> calib_start && !diag_start ##1 !calib_start && trig_r;
    endproperty
    a_proc_start: assert property (p_proc_start)
        else $error("calibration not launched once");

    property p_trig_held;
        state_r != ST_IDLE |-> trig_r;
    endproperty
    a_trig_held: assert property (p_trig_held)
        else $error("trigger dropped while busy");

    property p_abort;
        trig_w0 && seq_busy |=> state_r == ST_IDLE && !trig_r && !drive_en;
    endproperty
    a_abort: assert property (p_abort)
        else $error("clear did not abort playback");

    property p_reserved;
        reg_req.rd && reg_req.addr == ADDR_TRIG
        |=> reg_rdata[7:1] == 7'h00 && reg_rdata[0] == $past(trig_r);
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("trigger register read wrong");

    property p_od_closed;
        seg_take && closed_loop && lib_rsp.amp == peak_r
        |=> ms_r == {1'b0, $past(base_ms)} && drive_en;
    endproperty
    a_od_closed: assert property (p_od_closed)
        else $error("overdrive trim used in closed loop");

    property p_od_short;
        seg_take && !closed_loop && lib_rsp.amp == peak_r
        && lib_rsp.amp > 8'sh00 && $signed(odt_r) < 0 && base_ms != 16'h0
        |=> ms_r < {1'b0, $past(base_ms)};
    endproperty
    a_od_short: assert property (p_od_short)
        else $error("negative overdrive trim did not shorten");

    property p_sp_long;
        seg_take && lib_rsp.amp > 8'sh00 && lib_rsp.amp != peak_r
        && $signed(spt_r) > 0
        |=> ms_r > {1'b0, $past(base_ms)};
    endproperty
    a_sp_long: assert property (p_sp_long)
        else $error("positive sustain trim not applied");

    property p_zero_stop;
        state_r == ST_SLOT && cur == 8'h00 && !trig_w1
        |=> state_r == ST_IDLE && !trig_r
            ##1 (state_r == ST_IDLE || $past(trig_w1));
    endproperty
    a_zero_stop: assert property (p_zero_stop)
        else $error("sequence did not stop at zero id");

    property p_wait_load;
        state_r == ST_SLOT && cur[SLOT_WAIT_BIT] && !trig_w0
        |=> state_r == ST_WAIT && ms_r == 17'($past(cur[6:0]) * 10);
    endproperty
    a_wait_load: assert property (p_wait_load)
        else $error("wait slot time wrong");

    c_play_done: cover property (state_r == ST_RUN ##1 state_r == ST_IDLE);
    c_abort:     cover property (trig_w0 && state_r == ST_RUN);
    c_wait:      cover property (state_r == ST_WAIT ##1 state_r == ST_SLOT);
    c_calib:     cover property (calib_start ##[1:50] proc_done);

endmodule : hgt_top

// ### include/hgt_pkg.sv
// Constants and types for the haptic trigger and timing trim bank
package hgt_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_SLOT0 = 8'h04;
    localparam logic [7:0] ADDR_TRIG  = 8'h0C;
    localparam logic [7:0] ADDR_ODT   = 8'h0D;
    localparam logic [7:0] ADDR_SPT   = 8'h0E;

    // Field positions and counts
    localparam int NUM_SLOTS     = 8;
    localparam int TRIG_BIT      = 0;
    localparam int SLOT_WAIT_BIT = 7;

    // Reset values
    localparam logic       TRIG_RST = 1'h0;
    localparam logic [7:0] TRIM_RST = 8'h00;
    localparam logic [7:0] SLOT_RST = 8'h00;

    // Operating mode codes seen on the mode input
    localparam logic [2:0] MODE_SEQ   = 3'h0;
    localparam logic [2:0] MODE_DIAG  = 3'h6;
    localparam logic [2:0] MODE_CALIB = 3'h7;

    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
    localparam logic [16:0] WAIT_UNIT_MS = 17'h0000A;

    // Step interval choices in ms, picked by the select input
    localparam logic [7:0] INTERVAL_SLOW_MS = 8'h05;
    localparam logic [7:0] INTERVAL_FAST_MS = 8'h01;

    // Register access request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hgt_reg_req_s;

    // Library segment answer
    typedef struct packed {
        logic              ack;
        logic signed [7:0] amp;
        logic [7:0]        len;
        logic              last;
    } hgt_lib_rsp_s;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SLOT,
        ST_SCAN,
        ST_FETCH,
        ST_RUN,
        ST_WAIT,
        ST_PROC
    } hgt_state_e;

endpackage : hgt_pkg

// ### src/hgt_seg_dur.sv
// Segment duration with overdrive and positive sustain trims applied
`timescale 1ns/100ps
module hgt_seg_dur (
    input  wire logic signed [7:0] amp,
    input  wire logic signed [7:0] peak,
    input  wire logic [7:0]        len,
    input  wire logic [7:0]        interval_ms,
    input  wire logic signed [7:0] od_trim,
    input  wire logic signed [7:0] sp_trim,
    input  wire logic              closed_loop,
    output logic [15:0]            base_ms,
    output logic [16:0]            dur_ms
);
    import hgt_pkg::*;

    logic              is_od;
    logic              is_sp;
    logic signed [7:0] trim;
    logic signed [16:0] adj;
    logic signed [17:0] sum;

    // Classify the segment, pick its trim, scale and clamp at zero
    always_comb begin
        is_od   = (amp == peak) && (amp > 8'sh00);
        is_sp   = (amp > 8'sh00) && !is_od;
        if (is_od && !closed_loop) begin
            trim = od_trim;
        end else if (is_sp) begin
            trim = sp_trim;
        end else begin
            trim = 8'sh00;
        end
        base_ms = len * interval_ms;
        adj     = trim * $signed({1'b0, interval_ms});
        sum     = $signed({2'b00, base_ms}) + {adj[16], adj};
        dur_ms  = sum[17] ? 17'h00000 : sum[16:0];
    end

endmodule : hgt_seg_dur

// ### bench/hgt_lib_model.sv
// Waveform library model answering segment requests after a set latency
`timescale 1ns/100ps
module hgt_lib_model
    import hgt_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        lib_rd,
    input  wire logic [6:0]  lib_id,
    input  wire logic [3:0]  lib_seg,
    input  wire logic [3:0]  lat,
    output hgt_pkg::hgt_lib_rsp_s lib_rsp
);
    logic [3:0]  cnt;
    logic [16:0] junk;

    // Peak, sustain and negative tail; lines toggle when no answer is due
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt     <= 4'h0;
            junk    <= 17'h0A5A5;
            lib_rsp <= '0;
        end else begin
            junk    <= ~junk;
            lib_rsp <= {1'b0, junk};
            if (lib_rd) begin
                cnt <= lat;
            end else if (cnt == 4'h1) begin
                cnt <= 4'h0;
                case (lib_seg)
                    4'h0: lib_rsp <= '{1'b1, 8'h60, 8'(lib_id[1:0]) + 8'h01,
                                       1'b0};
                    4'h1: lib_rsp <= '{1'b1, 8'h20, 8'h02, 1'b0};
                    default: lib_rsp <= '{1'b1, 8'hE0, 8'h02, 1'b1};
                endcase
            end else if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule : hgt_lib_model

// ### bench/tb_top.sv
// Self-checking bench for the trigger and trim register bank
`timescale 1ns/100ps
module tb_top;
    import hgt_pkg::*;
    localparam int MSC = 16;
    logic         clk, rst_b, closed_loop, step_interval_select, proc_done;
    logic         lib_rd, drive_en, calib_start, diag_start, rd_pend, mon_on;
    logic [2:0]   op_mode;
    logic [3:0]   lat;
    logic [6:0]   lib_id;
    logic [3:0]   lib_seg;
    logic [7:0]   reg_rdata, drive_amp, cur, v, ra;
    logic [31:0]  seed;
    hgt_reg_req_s reg_req;
    hgt_lib_rsp_s lib_rsp;
    logic [15:0]  rd_q[$], seg_q[$];
    int           failures, n_compared, run, calib_n, diag_n, c0, d0, n;
    logic [2:0]   modes[3] = '{MODE_CALIB, MODE_DIAG, 3'h3};

    hgt_top #(.MS_CYCLES(MSC)) u_hgt_top (.clk(clk), .rst_b(rst_b),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .op_mode(op_mode),
        .closed_loop(closed_loop), .step_interval_select(step_interval_select),
        .proc_done(proc_done), .lib_rsp(lib_rsp), .lib_rd(lib_rd),
        .lib_id(lib_id), .lib_seg(lib_seg), .drive_en(drive_en),
        .drive_amp(drive_amp), .calib_start(calib_start),
        .diag_start(diag_start));
    hgt_lib_model u_hgt_lib_model (.clk(clk), .rst_b(rst_b), .lib_rd(lib_rd),
        .lib_id(lib_id), .lib_seg(lib_seg), .lat(lat), .lib_rsp(lib_rsp));

    always #25 clk = ~clk;

    task automatic report(input string m);
        failures++;
        $display("unexpected at %0t: %s", $time, m);
    endtask : report

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        reg_req <= '0;
    endtask : wr

    // Expected value goes in the queue with a mask in the upper byte
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        rd_q.push_back(e);
        @(posedge clk);
        reg_req <= '0;
    endtask : rd

    task automatic cmp_rd(input logic [15:0] e);
        if (e[15:8] != 8'h00) begin
            n_compared++;
            if ((reg_rdata & e[15:8]) !== e[7:0])
                report($sformatf("read %h want %h", reg_rdata, e[7:0]));
        end
    endtask : cmp_rd

    task automatic cmp_seg(input logic [7:0] a, input int ms);
        logic [15:0] e;
        n_compared++;
        if (seg_q.size() == 0) begin
            report("segment with nothing expected");
        end else begin
            e = seg_q.pop_front();
            if ({a, 8'(ms)} !== e)
                report($sformatf("segment %h/%0d want %h", a, ms, e));
        end
    endtask : cmp_seg

    task automatic cmp_bit(input logic a, input logic e, input string m);
        n_compared++;
        if (a !== e) report(m);
    endtask : cmp_bit

    // Three segments per waveform; first segment length follows the id
    task automatic exp_wave(input int id, od, sp, cl, step);
        seg_q.push_back({8'h60, 8'(((id % 4) + 1 + (cl ? 0 : od)) * step)});
        seg_q.push_back({8'h20, 8'((2 + sp) * step)});
        seg_q.push_back({8'hE0, 8'(2 * step)});
    endtask : exp_wave

    task automatic wait_clear(input int limit);
        int i;
        for (i = 0; i < limit; i++) begin
            rd(ADDR_TRIG, 16'h0000);
            #1;
            if (reg_rdata[0] === 1'b0) break;
        end
        cmp_bit(i < limit, 1'b1, "trigger never cleared");
    endtask : wait_clear

    task automatic wrap_up;
        if (seg_q.size() != 0) report("segments never played");
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    // Read answers are sampled one cycle after the strobe edge
    always @(posedge clk) begin
        if (rd_pend) cmp_rd(rd_q.pop_front());
        rd_pend <= reg_req.rd;
        if (calib_start === 1'b1) calib_n++;
        if (diag_start === 1'b1) diag_n++;
    end

    // Segment monitor: run length rounded to whole ms
    always @(posedge clk) begin
        if (run != 0 && (drive_en !== 1'b1 || drive_amp !== cur)) begin
            cmp_seg(cur, (run + MSC / 2) / MSC);
            run = 0;
        end
        if (drive_en === 1'b1 && mon_on) begin
            if (run == 0) cur = drive_amp;
            run++;
        end
    end

    // Watchdog
    initial begin
        repeat (30000) @(posedge clk);
        report("watchdog expired");
        wrap_up();
    end

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        reg_req = '0;
        op_mode = MODE_SEQ;
        closed_loop = 1'b0;
        step_interval_select = 1'b0;
        proc_done = 1'b0;
        lat = 4'h2;
        rd_pend = 1'b0;
        mon_on = 1'b1;
        seed = 32'h000013BA;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        // Reset values, random readback, unmapped place
        rd(ADDR_TRIG, 16'hFF00);
        rd(ADDR_ODT, 16'hFF00);
        rd(ADDR_SPT, 16'hFF00);
        foreach (modes[i]) begin
            seed = xs(seed);
            v = seed[7:0];
            ra = i == 0 ? ADDR_ODT : i == 1 ? ADDR_SPT : 8'h07;
            wr(ra, v);
            rd(ra, {8'hFF, v});
        end
        wr(8'h20, seed[15:8]);
        rd(8'h20, 16'hFF00);
        // Open loop, 5 ms step, wait slot between two waveforms
        wr(ADDR_ODT, 8'h01);
        wr(ADDR_SPT, 8'hFF);
        wr(8'h04, 8'h03);
        wr(8'h05, 8'h81);
        wr(8'h06, 8'h05);
        wr(8'h07, 8'h00);
        exp_wave(3, 1, -1, 0, 5);
        exp_wave(5, 1, -1, 0, 5);
        wr(ADDR_TRIG, 8'hFF);
        rd(ADDR_TRIG, 16'hFF01);
        wait_clear(3000);
        // Closed loop, 1 ms step, all eight slots full
        @(posedge clk);
        closed_loop <= 1'b1;
        step_interval_select <= 1'b1;
        lat <= 4'h1;
        wr(ADDR_ODT, 8'hFE);
        wr(ADDR_SPT, 8'h02);
        for (int i = 0; i < NUM_SLOTS; i++) begin
            wr(ADDR_SLOT0 + 8'(i), 8'(i + 1));
            exp_wave(i + 1, -2, 2, 1, 1);
        end
        wr(ADDR_TRIG, 8'h01);
        wait_clear(3000);
        // Abort in mid-play, slow library, open loop, shortened overdrive
        mon_on = 1'b0;
        @(posedge clk);
        lat <= 4'h9;
        closed_loop <= 1'b0;
        wr(ADDR_ODT, 8'hFF);
        wr(8'h04, 8'h02);
        wr(8'h05, 8'h00);
        wr(ADDR_TRIG, 8'h01);
        for (n = 0; n < 800 && drive_en !== 1'b1; n++) @(posedge clk);
        wr(ADDR_TRIG, 8'h00);
        @(posedge clk);
        #1 cmp_bit(drive_en, 1'b0, "drive still on after abort");
        n = 0;
        repeat (40) @(posedge clk) if (lib_rd === 1'b1) n++;
        cmp_bit(n == 0, 1'b1, "library read after abort");
        rd(ADDR_TRIG, 16'hFF00);
        mon_on = 1'b1;
        // Calibration, diagnostics and an unused mode
        foreach (modes[m]) begin
            @(posedge clk);
            op_mode <= modes[m];
            c0 = calib_n;
            d0 = diag_n;
            wr(ADDR_TRIG, 8'h01);
            repeat (3) @(posedge clk);
            #1 cmp_bit(calib_n == c0 + (m == 0), 1'b1, "calib start");
            cmp_bit(diag_n == d0 + (m == 1), 1'b1, "diag start");
            rd(ADDR_TRIG, m < 2 ? 16'hFF01 : 16'hFF00);
            @(posedge clk);
            proc_done <= 1'b1;
            @(posedge clk);
            proc_done <= 1'b0;
            rd(ADDR_TRIG, 16'hFF00);
        end
        repeat (4) @(posedge clk);
        wrap_up();
    end
endmodule : tb_top
